// ---- rtl/umr_pkg.sv ----
package umr_pkg;

    // Register offsets on the three-bit host address
    localparam logic [2:0] ADDR_DIV_LO = 3'h0;
    localparam logic [2:0] ADDR_DIV_HI = 3'h1;
    localparam logic [2:0] ADDR_TX_FREE = 3'h4;
    localparam logic [2:0] ADDR_RX_FILL = 3'h5;
    localparam logic [2:0] ADDR_STATUS = 3'h6;
    localparam logic [2:0] ADDR_SCRATCH = 3'h7;

    // Bank select control fields
    localparam int BANK_LSB = 1;
    localparam int BANK_MSB = 2;
    localparam int CNT_EN_BIT = 0;

    // Modem output control bit positions
    localparam int MOC_DTR = 0;
    localparam int MOC_RTS = 1;
    localparam int MOC_AUX_ONE = 2;
    localparam int MOC_AUX_TWO = 3;
    localparam int MOC_LOOP = 4;

    // Positions within the four-bit modem line nibble
    localparam int LINE_CTS = 0;
    localparam int LINE_DSR = 1;
    localparam int LINE_RI = 2;
    localparam int LINE_CD = 3;

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_LINES = 4'h0;
    localparam logic [3:0] RST_PINS = 4'hf;
    localparam int BUS_W = 14;
    localparam logic [BUS_W-1:0] RST_BUS = 14'h3800;

    typedef enum logic [1:0] {
        UMR_BANK_GENERAL = 2'b00,
        UMR_BANK_EXTRA_ONE = 2'b01,
        UMR_BANK_EXTRA_TWO = 2'b10,
        UMR_BANK_RSVD = 2'b11
    } umr_bank_t;

endpackage : umr_pkg

// ---- rtl/umr_status_if.sv ----
`timescale 1ns/1ps
interface umr_status_if;
    logic [3:0] level;
    logic [3:0] delta;
    logic clear;

    modport watch (
        output level,
        output delta,
        input clear
    );
    modport regs (
        input level,
        input delta,
        output clear
    );
endinterface : umr_status_if

// ---- rtl/umr_modem_watch.sv ----
`timescale 1ns/1ps
module umr_modem_watch (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cd_b,
    input wire logic ri_b,
    input wire logic dsr_b,
    input wire logic cts_b,
    input wire logic loopback,
    input wire logic [3:0] moc_bits,
    umr_status_if.watch st
);
    logic [3:0] pin_s1_reg, pin_s1_next;
    logic [3:0] pin_s2_reg, pin_s2_next;
    logic [3:0] level_reg, level_next;
    logic [3:0] delta_reg, delta_next;
    logic [3:0] eff;
    logic [3:0] loop_map;
    logic [3:0] set;

    // Two-stage synchroniser, then change detection on the effective level
    always_comb begin
        pin_s1_next = {cd_b, ri_b, dsr_b, cts_b}; // [R20]
        pin_s2_next = pin_s1_reg; // [R20]
        loop_map[umr_pkg::LINE_CTS] = moc_bits[umr_pkg::MOC_RTS]; // [R07]
        loop_map[umr_pkg::LINE_DSR] = moc_bits[umr_pkg::MOC_DTR]; // [R06]
        loop_map[umr_pkg::LINE_RI] = moc_bits[umr_pkg::MOC_AUX_ONE]; // [R05]
        loop_map[umr_pkg::LINE_CD] = moc_bits[umr_pkg::MOC_AUX_TWO]; // [R04]
        eff = loopback ? loop_map : ~pin_s2_reg; // [R04] [R05] [R06] [R07]
        set = eff ^ level_reg; // [R02] [R08]
        // Ring flag only on pin low-to-high, i.e. status falling
        set[umr_pkg::LINE_RI] = level_reg[umr_pkg::LINE_RI]
            & ~eff[umr_pkg::LINE_RI]; // [R09]
        level_next = eff;
        // Set beats a coinciding clear so no edge is lost
        delta_next = set | (delta_reg & ~{4{st.clear}}); // [R03] [R19]
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_reg <= umr_pkg::RST_PINS;
            pin_s2_reg <= umr_pkg::RST_PINS;
            level_reg <= umr_pkg::RST_LINES;
            delta_reg <= umr_pkg::RST_LINES;
        end else begin
            pin_s1_reg <= pin_s1_next;
            pin_s2_reg <= pin_s2_next;
            level_reg <= level_next;
            delta_reg <= delta_next;
        end
    end

    assign st.level = level_reg;
    assign st.delta = delta_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_loop_cd_ri;
        loopback |=> st.level[3] == $past(moc_bits[3])
            && st.level[2] == $past(moc_bits[2]);
    endproperty
    a_loop_cd_ri: assert property (p_loop_cd_ri) // [R04] [R05]
        else $error("loopback cd/ri mapping wrong");

    property p_loop_dsr_cts;
        loopback |=> st.level[1] == $past(moc_bits[0])
            && st.level[0] == $past(moc_bits[1]);
    endproperty
    a_loop_dsr_cts: assert property (p_loop_dsr_cts) // [R06] [R07]
        else $error("loopback dsr/cts mapping wrong");

    property p_pin_sync;
        !loopback ##1 !loopback ##1 !loopback
            |-> ##1 st.level[0] == !$past(cts_b, 3);
    endproperty
    a_pin_sync: assert property (p_pin_sync) // [R20]
        else $error("cts status not three cycles behind pin");

    // Each of CD, DSR and CTS is checked on its own flag
    property p_change_sets;
        (!$changed(st.level[3]) || st.delta[3])
            && (!$changed(st.level[1]) || st.delta[1])
            && (!$changed(st.level[0]) || st.delta[0]);
    endproperty
    a_change_sets: assert property (p_change_sets) // [R02] [R08] [R19]
        else $error("line change did not set its flag");

    property p_ri_edge;
        $rose(st.level[2]) && !$past(st.delta[2]) |-> !st.delta[2];
    endproperty
    a_ri_edge: assert property (p_ri_edge) // [R09]
        else $error("ring flag set on wrong edge");

    property p_ri_fall;
        $fell(st.level[2]) |-> st.delta[2];
    endproperty
    a_ri_fall: assert property (p_ri_fall) // [R09]
        else $error("ring flag missed trailing edge");

    property p_clear;
        $past(st.clear) && $stable(st.level) |-> st.delta == 4'h0;
    endproperty
    a_clear: assert property (p_clear) // [R03]
        else $error("flags not cleared by status read");

    c_loop_change: cover property (loopback && $changed(st.level));
endmodule : umr_modem_watch

// ---- rtl/umr_regs.sv ----
`timescale 1ns/1ps
// Operation
// R01: Status read and bank select write share one address.
// R02: Each low status flag except ring sets when its modem line changes.
// R03: Reading status clears all change flags.
// R04: Bit 7 is inverted carrier detect, or aux output two in loopback.
// R05: Bit 6 is inverted ring indicator, or aux output one in loopback.
// R06: Bit 5 is inverted DSR, or DTR control bit in loopback.
// R07: Bit 4 is inverted CTS, or RTS control bit in loopback.
// R08: Bits 3, 1, 0 flag any change of CD, DSR, CTS; reset zero.
// R09: Ring flag sets only when ring pin rises from 0 to 1.
// R10: Modem interrupt raised while any change flag is set.
// R11: Bank select is write-only; upper five bits unused.
// R12: Bank field picks general, extra one, extra two; 11 reserved.
// R13: Counter enable bit makes level counters readable. Code also keeps them unreadable while dlab is set.
// R14: Bank field overrides counter enable; counters only in general bank.
// R15: Scratch byte stores and returns host data, nothing else.
// R16: Baud divisor is sixteen bits from high and low bytes.
// R17: Transmit counter reads free transmit FIFO entries, read-only.
// R18: Receive counter reads characters held in receive FIFO, read-only.
// R19: Change coinciding with status read keeps its flag set.
// R20: Modem inputs synchronised before change detection.
module umr_regs (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cs_b,
    input wire logic rd_b,
    input wire logic wr_b,
    input wire logic [2:0] addr,
    input wire logic [7:0] data_in,
    input wire logic cd_b,
    input wire logic ri_b,
    input wire logic dsr_b,
    input wire logic cts_b,
    input wire logic [4:0] modem_output_control,
    input wire logic dlab,
    input wire logic [7:0] tx_free_space_count,
    input wire logic [7:0] rx_fill_count,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic modem_irq,
    output logic [1:0] bank_sel,
    output logic [15:0] baud_divisor
);
    umr_status_if st ();

    logic [umr_pkg::BUS_W-1:0] bus_s1_reg, bus_s1_next;
    logic [umr_pkg::BUS_W-1:0] bus_s2_reg, bus_s2_next;
    logic rd_prev_reg, rd_prev_next;
    logic wr_prev_reg, wr_prev_next;
    logic s_cs_b, s_rd_b, s_wr_b;
    logic [2:0] s_addr;
    logic [7:0] s_data;
    logic rd_act, wr_act, rd_start, wr_start;

    umr_pkg::umr_bank_t bank_reg, bank_next;
    logic cnt_en_reg, cnt_en_next;
    logic [7:0] scratch_byte_reg, scratch_byte_next;
    logic [7:0] baud_divisor_low_reg, baud_divisor_low_next;
    logic [7:0] baud_divisor_high_reg, baud_divisor_high_next;
    logic [15:0] baud_divisor_reg, baud_divisor_next;
    logic [7:0] data_out_reg, data_out_next;
    logic data_oe_reg, data_oe_next;
    logic modem_irq_reg, modem_irq_next;
    logic [7:0] rd_mux;
    logic rd_hit;
    logic [7:0] modem_input_status;

    // General bank gates the ordinary registers
    function automatic logic gen_open(input umr_pkg::umr_bank_t b);
        gen_open = (b == umr_pkg::UMR_BANK_GENERAL);
    endfunction : gen_open

    // Level counters need the general bank first, then the enable bit, then dlab clear
    function automatic logic cnt_open(input umr_pkg::umr_bank_t b,
                                      input logic en, input logic dl);
        cnt_open = gen_open(b) && en && !dl; // [R13] [R14]
    endfunction : cnt_open

    umr_modem_watch u_watch (
        .clk(clk),
        .rst_b(rst_b),
        .cd_b(cd_b),
        .ri_b(ri_b),
        .dsr_b(dsr_b),
        .cts_b(cts_b),
        .loopback(modem_output_control[umr_pkg::MOC_LOOP]),
        .moc_bits(modem_output_control[3:0]),
        .st(st.watch)
    );

    // Host pins cross in through two flops; strobes and fields together
    always_comb begin
        bus_s1_next = {cs_b, rd_b, wr_b, addr, data_in};
        bus_s2_next = bus_s1_reg;
        {s_cs_b, s_rd_b, s_wr_b, s_addr, s_data} = bus_s2_reg;
        rd_act = !s_cs_b && !s_rd_b;
        wr_act = !s_cs_b && !s_wr_b;
        rd_start = rd_act && !rd_prev_reg;
        wr_start = wr_act && !wr_prev_reg;
        rd_prev_next = rd_act;
        wr_prev_next = wr_act;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_s1_reg <= umr_pkg::RST_BUS;
            bus_s2_reg <= umr_pkg::RST_BUS;
            rd_prev_reg <= 1'b0;
            wr_prev_reg <= 1'b0;
        end else begin
            bus_s1_reg <= bus_s1_next;
            bus_s2_reg <= bus_s2_next;
            rd_prev_reg <= rd_prev_next;
            wr_prev_reg <= wr_prev_next;
        end
    end

    // Read decode; unmapped or gated addresses leave the bus undriven
    always_comb begin
        modem_input_status = {st.level, st.delta}; // [R01]
        rd_mux = umr_pkg::RST_BYTE;
        rd_hit = 1'b0;
        unique case (s_addr)
            umr_pkg::ADDR_STATUS: begin
                rd_mux = modem_input_status; // [R01]
                rd_hit = 1'b1;
            end
            umr_pkg::ADDR_DIV_LO: begin
                rd_mux = baud_divisor_low_reg;
                rd_hit = gen_open(bank_reg) && dlab;
            end
            umr_pkg::ADDR_DIV_HI: begin
                rd_mux = baud_divisor_high_reg;
                rd_hit = gen_open(bank_reg) && dlab;
            end
            umr_pkg::ADDR_SCRATCH: begin
                rd_mux = scratch_byte_reg; // [R15]
                rd_hit = gen_open(bank_reg);
            end
            umr_pkg::ADDR_TX_FREE: begin
                rd_mux = tx_free_space_count; // [R17]
                rd_hit = cnt_open(bank_reg, cnt_en_reg, dlab); // [R14]
            end
            umr_pkg::ADDR_RX_FILL: begin
                rd_mux = rx_fill_count; // [R18]
                rd_hit = cnt_open(bank_reg, cnt_en_reg, dlab); // [R14]
            end
            default: begin
                rd_mux = umr_pkg::RST_BYTE;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Clear pulse shares the edge that latches the status byte
    assign st.clear = rd_start && (s_addr == umr_pkg::ADDR_STATUS); // [R03]

    // Read data held steady for the whole strobe
    always_comb begin
        data_out_next = data_out_reg;
        data_oe_next = data_oe_reg && rd_act;
        if (rd_start) begin
            data_out_next = rd_mux;
            data_oe_next = rd_hit;
        end
        modem_irq_next = |st.delta; // [R10]
    end

    // Writes; the status address writes bank select only
    always_comb begin
        bank_next = bank_reg;
        cnt_en_next = cnt_en_reg;
        scratch_byte_next = scratch_byte_reg;
        baud_divisor_low_next = baud_divisor_low_reg;
        baud_divisor_high_next = baud_divisor_high_reg;
        if (wr_start) begin
            unique case (s_addr)
                umr_pkg::ADDR_STATUS: begin
                    // Upper bits dropped; nothing reads them back
                    bank_next = umr_pkg::umr_bank_t'( // [R11] [R12]
                        s_data[umr_pkg::BANK_MSB:umr_pkg::BANK_LSB]);
                    cnt_en_next = s_data[umr_pkg::CNT_EN_BIT]; // [R13]
                end
                umr_pkg::ADDR_DIV_LO: begin
                    if (gen_open(bank_reg) && dlab) begin
                        baud_divisor_low_next = s_data; // [R16]
                    end
                end
                umr_pkg::ADDR_DIV_HI: begin
                    if (gen_open(bank_reg) && dlab) begin
                        baud_divisor_high_next = s_data; // [R16]
                    end
                end
                umr_pkg::ADDR_SCRATCH: begin
                    if (gen_open(bank_reg)) begin
                        scratch_byte_next = s_data; // [R15]
                    end
                end
                default: begin
                    bank_next = bank_reg;
                end
            endcase
        end
        baud_divisor_next = {baud_divisor_high_reg, // [R16]
            baud_divisor_low_reg};
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bank_reg <= umr_pkg::UMR_BANK_GENERAL;
            cnt_en_reg <= 1'b0;
            scratch_byte_reg <= umr_pkg::RST_BYTE;
            baud_divisor_low_reg <= umr_pkg::RST_BYTE;
            baud_divisor_high_reg <= umr_pkg::RST_BYTE;
            baud_divisor_reg <= {umr_pkg::RST_BYTE, umr_pkg::RST_BYTE};
            data_out_reg <= umr_pkg::RST_BYTE;
            data_oe_reg <= 1'b0;
            modem_irq_reg <= 1'b0;
        end else begin
            bank_reg <= bank_next;
            cnt_en_reg <= cnt_en_next;
            scratch_byte_reg <= scratch_byte_next;
            baud_divisor_low_reg <= baud_divisor_low_next;
            baud_divisor_high_reg <= baud_divisor_high_next;
            baud_divisor_reg <= baud_divisor_next;
            data_out_reg <= data_out_next;
            data_oe_reg <= data_oe_next;
            modem_irq_reg <= modem_irq_next;
        end
    end

    assign data_out = data_out_reg;
    assign data_oe = data_oe_reg;
    assign modem_irq = modem_irq_reg;
    assign bank_sel = bank_reg;
    assign baud_divisor = baud_divisor_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_status_read;
        rd_start && s_addr == umr_pkg::ADDR_STATUS
            |=> data_oe && data_out == $past({st.level, st.delta});
    endproperty
    a_status_read: assert property (p_status_read) // [R01]
        else $error("status read returned wrong byte");

    property p_bank_write;
        wr_start && s_addr == umr_pkg::ADDR_STATUS
            |=> bank_sel == $past(s_data[umr_pkg::BANK_MSB:umr_pkg::BANK_LSB])
            && cnt_en_reg == $past(s_data[umr_pkg::CNT_EN_BIT]);
    endproperty
    a_bank_write: assert property (p_bank_write) // [R01] [R12] [R13]
        else $error("bank select not written at status address");

    property p_irq;
        st.delta != 4'h0 ##1 st.delta != 4'h0 |-> modem_irq;
    endproperty
    a_irq: assert property (p_irq) // [R10]
        else $error("modem interrupt missing with flag set");

    property p_irq_idle;
        st.delta == 4'h0 |=> !modem_irq;
    endproperty
    a_irq_idle: assert property (p_irq_idle) // [R10]
        else $error("modem interrupt without any flag");

    property p_cnt_gate;
        rd_start && (s_addr == umr_pkg::ADDR_TX_FREE
            || s_addr == umr_pkg::ADDR_RX_FILL)
            && (bank_reg != umr_pkg::UMR_BANK_GENERAL || !cnt_en_reg)
            |=> !data_oe;
    endproperty
    a_cnt_gate: assert property (p_cnt_gate) // [R13] [R14]
        else $error("level counter readable while gated");

    property p_tx_read;
        rd_start && s_addr == umr_pkg::ADDR_TX_FREE
            && cnt_open(bank_reg, cnt_en_reg, dlab)
            |=> data_oe && data_out == $past(tx_free_space_count);
    endproperty
    a_tx_read: assert property (p_tx_read) // [R17]
        else $error("transmit counter read wrong");

    property p_rx_read;
        rd_start && s_addr == umr_pkg::ADDR_RX_FILL
            && cnt_open(bank_reg, cnt_en_reg, dlab)
            |=> data_oe && data_out == $past(rx_fill_count);
    endproperty
    a_rx_read: assert property (p_rx_read) // [R18]
        else $error("receive counter read wrong");

    property p_scratch;
        wr_start && s_addr == umr_pkg::ADDR_SCRATCH
            && bank_reg == umr_pkg::UMR_BANK_GENERAL
            |=> scratch_byte_reg == $past(s_data);
    endproperty
    a_scratch: assert property (p_scratch) // [R15]
        else $error("scratch byte not stored");

    property p_divisor;
        wr_start && s_addr == umr_pkg::ADDR_DIV_HI && dlab
            && bank_reg == umr_pkg::UMR_BANK_GENERAL
            |-> ##2 baud_divisor[15:8] == $past(s_data, 2);
    endproperty
    a_divisor: assert property (p_divisor) // [R16]
        else $error("divisor high byte not applied");

    property p_oe_release;
        !rd_act |=> !data_oe;
    endproperty
    a_oe_release: assert property (p_oe_release)
        else $error("data driven after read strobe ended");

    c_status_flags: cover property (st.clear && st.delta != 4'h0);
    c_bank_extra: cover property (wr_start
        && s_addr == umr_pkg::ADDR_STATUS && s_data[2:1] == 2'b01);
    c_cnt_read: cover property (rd_start && s_addr == umr_pkg::ADDR_RX_FILL
        && rd_hit);
    c_irq: cover property ($rose(modem_irq));
endmodule : umr_regs

// ---- dv/umr_modem_model.sv ----
`timescale 1ns/1ps
// Modem side: drives the four active-low control lines
module umr_modem_model (
    input wire logic clk,
    output logic cd_b,
    output logic ri_b,
    output logic dsr_b,
    output logic cts_b
);
    logic [3:0] pins_reg;

    // Lines idle high (inactive) until the bench commands a change
    initial pins_reg = 4'hf;

    // Nibble order matches the status byte's line nibble
    assign cts_b = pins_reg[umr_pkg::LINE_CTS];
    assign dsr_b = pins_reg[umr_pkg::LINE_DSR];
    assign ri_b = pins_reg[umr_pkg::LINE_RI];
    assign cd_b = pins_reg[umr_pkg::LINE_CD];

    // Changes land just after an edge; lines are never left floating
    task automatic drive(input int n, input logic v);
        @(posedge clk);
        pins_reg[n] <= v;
    endtask : drive
endmodule : umr_modem_model

// ---- dv/umr_regs_tb.sv ----
`timescale 1ns/1ps
module umr_regs_tb;
    logic clk, rst_b, cs_b, rd_b, wr_b, dlab, data_oe, modem_irq, oe;
    logic cd_b, ri_b, dsr_b, cts_b, en, exp_oe;
    logic [2:0] addr, a;
    logic [7:0] data_in, data_out, tx_cnt, rx_cnt, scr, q, lo, hi, d, expd;
    logic [4:0] moc;
    logic [1:0] bank_sel, bk;
    logic [15:0] baud_divisor;
    logic [3:0] pins, flags;
    integer err_count, checked, seed, cycles, i, j, idx;

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    umr_modem_model mdl_u (.clk(clk), .cd_b(cd_b), .ri_b(ri_b),
        .dsr_b(dsr_b), .cts_b(cts_b));

    umr_regs dut_u (.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .rd_b(rd_b),
        .wr_b(wr_b), .addr(addr), .data_in(data_in), .cd_b(cd_b),
        .ri_b(ri_b), .dsr_b(dsr_b), .cts_b(cts_b),
        .modem_output_control(moc), .dlab(dlab),
        .tx_free_space_count(tx_cnt), .rx_fill_count(rx_cnt),
        .data_out(data_out), .data_oe(data_oe), .modem_irq(modem_irq),
        .bank_sel(bank_sel), .baud_divisor(baud_divisor));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask : check

    task automatic results;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    // Pin-level access; strobes held long enough for the synchronisers
    task automatic bus(input logic [2:0] ad, input logic wr,
                       input logic [7:0] dt, output logic o,
                       output logic [7:0] r);
        @(posedge clk);
        addr <= ad;
        data_in <= dt;
        @(posedge clk);
        cs_b <= 1'b0;
        if (wr) wr_b <= 1'b0;
        else rd_b <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        o = data_oe;
        r = data_out;
        @(posedge clk);
        cs_b <= 1'b1;
        rd_b <= 1'b1;
        wr_b <= 1'b1;
        // Release must be seen before the next access starts
        repeat (5) @(posedge clk);
    endtask : bus

    // Model: flag on any change, ring only on a pin rise
    task automatic set_pin(input integer n, input logic v);
        mdl_u.drive(n, v);
        if (pins[n] !== v) begin
            if (n != umr_pkg::LINE_RI || v) flags[n] = 1'b1;
            pins[n] = v;
        end
        repeat (6) @(posedge clk);
        check(modem_irq, |flags);
    endtask : set_pin

    // Status read compared with the model, then the model clears
    task automatic rd_status;
        bus(umr_pkg::ADDR_STATUS, 1'b0, 8'h00, oe, q);
        check({oe, q}, {1'b1, ~pins, flags});
        flags = 4'h0;
        check(modem_irq, 1'b0);
    endtask : rd_status

    // Hang guard, generous against roughly 1450 cycles of traffic
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            err_count = err_count + 1;
            results();
        end
    end

    initial begin
        seed = 32'hdb393e91;
        err_count = 0;
        checked = 0;
        cycles = 0;
        rst_b = 1'b0;
        cs_b = 1'b1;
        rd_b = 1'b1;
        wr_b = 1'b1;
        addr = 3'h0;
        data_in = 8'h00;
        dlab = 1'b0;
        moc = 5'h00;
        tx_cnt = 8'h00;
        rx_cnt = 8'h00;
        pins = 4'hf;
        flags = 4'h0;
        scr = 8'h00;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        check(baud_divisor, 16'h0000);
        check({data_oe, modem_irq, bank_sel}, 16'h0000);
        // Scratch byte round trips
        for (i = 0; i < 4; i++) begin
            scr = 8'($random(seed));
            bus(umr_pkg::ADDR_SCRATCH, 1'b1, scr, oe, q);
            bus(umr_pkg::ADDR_SCRATCH, 1'b0, 8'h00, oe, q);
            check({oe, q}, {1'b1, scr});
        end
        // Divisor bytes with the latch access bit set
        dlab <= 1'b1;
        for (i = 0; i < 3; i++) begin
            lo = 8'($random(seed));
            hi = 8'($random(seed));
            bus(umr_pkg::ADDR_DIV_LO, 1'b1, lo, oe, q);
            bus(umr_pkg::ADDR_DIV_HI, 1'b1, hi, oe, q);
            check(baud_divisor, {hi, lo});
            bus(umr_pkg::ADDR_DIV_HI, 1'b0, 8'h00, oe, q);
            check({oe, q}, {1'b1, hi});
        end
        dlab <= 1'b0;
        // Every line both ways, each change read on its own
        for (i = 0; i < 4; i++) begin
            set_pin(i, 1'b0);
            rd_status;
            set_pin(i, 1'b1);
            rd_status;
        end
        // Random toggles, several changes piling up between reads
        for (i = 0; i < 12; i++) begin
            idx = $unsigned($random(seed)) % 4;
            set_pin(idx, ~pins[idx]);
            if (i % 3 == 2) rd_status;
        end
        rd_status;
        // Loopback: second read sees looped bits and no new flags
        for (i = 0; i < 4; i++) begin
            lo = 8'($random(seed));
            moc <= {1'b1, lo[3:0]};
            repeat (6) @(posedge clk);
            bus(umr_pkg::ADDR_STATUS, 1'b0, 8'h00, oe, q);
            bus(umr_pkg::ADDR_STATUS, 1'b0, 8'h00, oe, q);
            check({oe, q},
                {1'b1, lo[3], lo[2], lo[0], lo[1], 4'h0});
        end
        moc <= 5'h00;
        repeat (6) @(posedge clk);
        bus(umr_pkg::ADDR_STATUS, 1'b0, 8'h00, oe, q);
        flags = 4'h0;
        rd_status;
        // Every bank and enable against counters and scratch
        for (j = 0; j < 24; j++) begin
            bk = 2'(j / 6);
            en = 1'((j / 3) % 2);
            a = (j % 3 == 0) ? umr_pkg::ADDR_TX_FREE :
                (j % 3 == 1) ? umr_pkg::ADDR_RX_FILL : umr_pkg::ADDR_SCRATCH;
            d = 8'($random(seed));
            d[2:0] = {bk, en};
            bus(umr_pkg::ADDR_STATUS, 1'b1, d, oe, q);
            check(bank_sel, bk);
            tx_cnt <= 8'($random(seed));
            rx_cnt <= 8'($random(seed));
            // Counter writes must be dropped
            if (a != umr_pkg::ADDR_SCRATCH) bus(a, 1'b1, d, oe, q);
            if (j == 9) rd_status;
            exp_oe = (bk == 2'b00) && (a == umr_pkg::ADDR_SCRATCH || en);
            expd = (a == umr_pkg::ADDR_TX_FREE) ? tx_cnt :
                   (a == umr_pkg::ADDR_RX_FILL) ? rx_cnt : scr;
            bus(a, 1'b0, 8'h00, oe, q);
            check(oe, exp_oe);
            if (exp_oe) check(q, expd);
        end
        bus(umr_pkg::ADDR_STATUS, 1'b1, 8'h00, oe, q);
        check(bank_sel, 2'b00);
        results();
    end
endmodule : umr_regs_tb
